// file: src/cag_pkg.sv
// Package of constants and types for the address generation block.
package cag_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets on the register bus
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_PTR0 = 6'h00;
  localparam logic [5:0] OFF_PTR1 = 6'h04;
  localparam logic [5:0] OFF_ALU_STATUS = 6'h08;
  localparam logic [5:0] OFF_BANK_SELECT = 6'h0C;
  localparam logic [5:0] OFF_TABLE_PTR_LOW = 6'h10;
  localparam logic [5:0] OFF_TABLE_PTR_HIGH = 6'h14;
  localparam logic [5:0] OFF_PC_LOW = 6'h18;
  localparam logic [5:0] OFF_PC_LATCH = 6'h1C;
  localparam logic [5:0] OFF_PC_FULL = 6'h20;
  // ----------------------------------------------------------------
  // Field positions inside the ALU status register
  // ----------------------------------------------------------------
  localparam int MODE1_LSB = 6;
  localparam int MODE0_LSB = 4;
  localparam int ZERO_BIT = 2;
  // ----------------------------------------------------------------
  // Pointer mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_DEC = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  // ----------------------------------------------------------------
  // Data space landmarks
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IND_PORT0 = 8'h00;
  localparam logic [7:0] ADDR_IND_PORT1 = 8'h08;
  localparam logic [7:0] ADDR_PERIPH_LO = 8'h10;
  localparam logic [7:0] ADDR_PERIPH_HI = 8'h17;
  localparam logic [7:0] ADDR_RAM_BANKED = 8'h20;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_ALU_STATUS = 8'hF0;
  localparam logic [15:0] RST_PC = 16'h0000;
  // ----------------------------------------------------------------
  // Timing: core clock cycles per instruction cycle
  // ----------------------------------------------------------------
  localparam int CYCLES_PER_INSTR = 4;
  // ----------------------------------------------------------------
  // Program counter operations presented by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PC_INCR = 3'h0,
    PC_LONG_CALL = 3'h1,
    PC_CALL_JUMP = 3'h2,
    PC_RETURN = 3'h3,
    PC_VECTOR = 3'h4,
    PC_WRITE_LOW = 3'h5,
    PC_RMW_LOW = 3'h6,
    PC_SKIP = 3'h7
  } cag_pc_op_e;
endpackage

// file: src/cag_core.sv
// Address generation: data pointers, program counter, bank select.
`timescale 1ns/1ps
// Function
// - Indirect port access reaches data memory at the matching 8-bit pointer.
// - Indirect read of a port gives zero, sets Z; write is a no-op.
// - Pointer of zero: read gives zero and sets Z; write is a no-op.
// - Two mode bits per pointer in status: upper pair one, lower zero.
// - Mode 00 post-decrements, 01 post-increments, 1x leaves pointer alone.
// - Pointer auto-update never changes any status flag.
// - Banked indirect targets use the current bank select value.
// - Indirect move transfers finish within one instruction cycle.
// - Two table pointer bytes form a 16-bit program memory address.
// - A 16-bit table latch, high and low bytes, not data mapped.
// - 16-bit counter; low byte mapped, high byte read only in the full word, written only via holding latch.
// - Counter increments each fetch in the first phase unless redirected.
// - Skipped instruction runs as forced no-op at its address.
// - Long call: high from latch, low from opcode bits 7..0.
// - Reading counter low byte copies counter high byte into latch.
// - Writing counter low byte also moves latch into high byte.
// - Read-modify-write on low byte writes result, high from latch.
// - Call/jump: opcode 12..0 to counter; latch gets pc 15..13, op 12..8.
// - Latch untouched by long call, returns, vectoring, low byte RMW.
// - Low bank nibble selects peripheral bank for 10h-17h, own load op.
// - High bank nibble selects RAM bank, loaded by its own op.
// - Unimplemented bank: reads zero, writes dropped, flags still updated.
module cag_core #(
  parameter logic [15:0] PERIPH_BANKS = 16'h00FF,
  parameter logic [15:0] RAM_BANKS = 16'h000F,
  parameter int INSTR_CYCLES = cag_pkg::CYCLES_PER_INSTR
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] pc_op,
  input wire logic [15:0] opcode,
  input wire logic [7:0] pc_wdata,
  input wire logic [15:0] stack_top,
  input wire logic [15:0] vector_addr,
  input wire logic pcl_read,
  input wire logic load_peripheral_bank,
  input wire logic load_ram_bank,
  input wire logic alu_flag_we,
  input wire logic [3:0] alu_flags,
  input wire logic ind_req,
  input wire logic ind_write,
  input wire logic ind_sel,
  input wire logic [7:0] ind_wdata,
  input wire logic [7:0] dmem_rdata,
  input wire logic table_latch_load,
  input wire logic [15:0] table_latch_data,
  output logic first_clock_phase,
  output logic [15:0] pc_out,
  output logic forced_nop,
  output logic [7:0] pc_high_holding_latch,
  output logic [7:0] alu_status_register,
  output logic [7:0] bank_select_register,
  output logic [15:0] table_addr,
  output logic [15:0] table_holding_latch,
  output logic [7:0] dmem_addr,
  output logic [3:0] dmem_bank,
  output logic dmem_re,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  output logic ind_busy,
  output logic ind_done,
  output logic [7:0] ind_rdata
);
  initial begin
    if (INSTR_CYCLES < 2 || INSTR_CYCLES > 16) begin
      $error("INSTR_CYCLES must lie between 2 and 16");
    end
  end

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  logic [3:0] phase_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt_reg <= 4'h0;
      first_clock_phase <= 1'b0;
    end else begin
      first_clock_phase <= (phase_cnt_reg == 4'h0);
      if (phase_cnt_reg == 4'(INSTR_CYCLES - 1)) begin
        phase_cnt_reg <= 4'h0;
      end else begin
        phase_cnt_reg <= phase_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave: one wait cycle, then completion
  // ----------------------------------------------------------------
  logic [7:0] ptr0_reg;
  logic [7:0] ptr1_reg;
  logic bus_req;
  logic bus_done;
  logic wr_lo;
  logic [7:0] wbyte;
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !avs_waitrequest;
  assign wr_lo = bus_done && avs_write && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest && avs_read) begin
        case (avs_address)
          cag_pkg::OFF_PTR0: avs_readdata <= {24'h0, ptr0_reg};
          cag_pkg::OFF_PTR1: avs_readdata <= {24'h0, ptr1_reg};
          cag_pkg::OFF_ALU_STATUS:
            avs_readdata <= {24'h0, alu_status_register};
          cag_pkg::OFF_BANK_SELECT:
            avs_readdata <= {24'h0, bank_select_register};
          cag_pkg::OFF_TABLE_PTR_LOW:
            avs_readdata <= {24'h0, table_addr[7:0]};
          cag_pkg::OFF_TABLE_PTR_HIGH:
            avs_readdata <= {24'h0, table_addr[15:8]};
          cag_pkg::OFF_PC_LOW: avs_readdata <= {24'h0, pc_out[7:0]};
          cag_pkg::OFF_PC_LATCH:
            avs_readdata <= {24'h0, pc_high_holding_latch};
          cag_pkg::OFF_PC_FULL: avs_readdata <= {16'h0, pc_out};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic pcl_bus_write;
  logic pcl_bus_read;
  logic op_take;
  cag_pkg::cag_pc_op_e op;
  assign op = cag_pkg::cag_pc_op_e'(pc_op);
  assign op_take = first_clock_phase;
  assign pcl_bus_write = wr_lo && (avs_address == cag_pkg::OFF_PC_LOW);
  assign pcl_bus_read = bus_done && avs_read &&
                        (avs_address == cag_pkg::OFF_PC_LOW);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_out <= cag_pkg::RST_PC;
    end else if (pcl_bus_write) begin
      pc_out <= {pc_high_holding_latch, wbyte};
    end else if (op_take) begin
      case (op)
        cag_pkg::PC_LONG_CALL:
          pc_out <= {pc_high_holding_latch, opcode[7:0]};
        cag_pkg::PC_CALL_JUMP:
          pc_out <= {pc_out[15:13], opcode[12:0]};
        cag_pkg::PC_RETURN: pc_out <= stack_top;
        cag_pkg::PC_VECTOR: pc_out <= vector_addr;
        cag_pkg::PC_WRITE_LOW:
          pc_out <= {pc_high_holding_latch, pc_wdata};
        cag_pkg::PC_RMW_LOW:
          pc_out <= {pc_high_holding_latch, pc_wdata};
        default: pc_out <= pc_out + 16'h0001;
      endcase
    end
  end

  // A skipped instruction still occupies its slot as a no-op.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      forced_nop <= 1'b0;
    end else if (op_take) begin
      forced_nop <= (op == cag_pkg::PC_SKIP);
    end
  end

  // The latch copy on a low byte read is suppressed for RMW, which
  // must leave the latch as the page select for its own jump.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_holding_latch <= cag_pkg::RST_BYTE;
    end else if (wr_lo && avs_address == cag_pkg::OFF_PC_LATCH) begin
      pc_high_holding_latch <= wbyte;
    end else if (op_take && op == cag_pkg::PC_CALL_JUMP) begin
      pc_high_holding_latch <= {pc_out[15:13], opcode[12:8]};
    end else if (pcl_bus_read ||
                 (pcl_read && !(op_take && op == cag_pkg::PC_RMW_LOW))) begin
      pc_high_holding_latch <= pc_out[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Bank select and table pointer / latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_register <= cag_pkg::RST_BYTE;
    end else if (wr_lo && avs_address == cag_pkg::OFF_BANK_SELECT) begin
      bank_select_register <= wbyte;
    end else begin
      if (load_peripheral_bank) begin
        bank_select_register[3:0] <= opcode[3:0];
      end
      if (load_ram_bank) begin
        bank_select_register[7:4] <= opcode[7:4];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_addr <= {cag_pkg::RST_BYTE, cag_pkg::RST_BYTE};
    end else if (wr_lo && avs_address == cag_pkg::OFF_TABLE_PTR_LOW) begin
      table_addr[7:0] <= wbyte;
    end else if (wr_lo && avs_address == cag_pkg::OFF_TABLE_PTR_HIGH) begin
      table_addr[15:8] <= wbyte;
    end
  end

  // Deliberately absent from the bus map: only transfers load it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_holding_latch <= {cag_pkg::RST_BYTE, cag_pkg::RST_BYTE};
    end else if (table_latch_load) begin
      table_holding_latch <= table_latch_data;
    end
  end

  // ----------------------------------------------------------------
  // Indirect access, stage one: decode pointer into a memory request
  // ----------------------------------------------------------------
  logic [7:0] ind_addr;
  logic ind_take;
  logic to_port;
  logic forced;
  logic periph_win;
  logic ram_win;
  logic [3:0] bank_next;
  logic impl;
  logic acc_sel_reg;
  logic acc_wr_reg;
  logic acc_void_reg;

  assign ind_take = ind_req && !ind_busy;
  assign ind_addr = ind_sel ? ptr1_reg : ptr0_reg;
  assign to_port = (ind_addr == cag_pkg::ADDR_IND_PORT0) ||
                   (ind_addr == cag_pkg::ADDR_IND_PORT1);
  assign forced = to_port || (ind_addr == 8'h00);
  assign periph_win = (ind_addr >= cag_pkg::ADDR_PERIPH_LO) &&
                      (ind_addr <= cag_pkg::ADDR_PERIPH_HI);
  assign ram_win = (ind_addr >= cag_pkg::ADDR_RAM_BANKED);
  assign bank_next = periph_win ? bank_select_register[3:0] :
                     ram_win ? bank_select_register[7:4] : 4'h0;
  assign impl = periph_win ? PERIPH_BANKS[bank_next] :
                ram_win ? RAM_BANKS[bank_next] : 1'b1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_busy <= 1'b0;
      dmem_addr <= cag_pkg::RST_BYTE;
      dmem_bank <= 4'h0;
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      dmem_wdata <= cag_pkg::RST_BYTE;
      acc_sel_reg <= 1'b0;
      acc_wr_reg <= 1'b0;
      acc_void_reg <= 1'b0;
    end else begin
      ind_busy <= ind_take;
      dmem_re <= ind_take && !ind_write && !forced && impl;
      dmem_we <= ind_take && ind_write && !forced && impl;
      if (ind_take) begin
        dmem_addr <= ind_addr;
        dmem_bank <= bank_next;
        dmem_wdata <= ind_wdata;
        acc_sel_reg <= ind_sel;
        acc_wr_reg <= ind_write;
        acc_void_reg <= forced || !impl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage two: result and pointer post-update, on the same edge
  // ----------------------------------------------------------------
  logic zero_set;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_done <= 1'b0;
      ind_rdata <= cag_pkg::RST_BYTE;
      zero_set <= 1'b0;
    end else begin
      ind_done <= ind_busy;
      zero_set <= 1'b0;
      if (ind_busy && !acc_wr_reg) begin
        ind_rdata <= acc_void_reg ? 8'h00 : dmem_rdata;
        zero_set <= acc_void_reg;
      end
    end
  end

  function automatic logic [7:0] step_ptr(input logic [7:0] p,
                                          input logic [1:0] m);
    logic [7:0] r;
    r = p;
    if (m == cag_pkg::MODE_DEC) begin
      r = p - 8'h01;
    end else if (m == cag_pkg::MODE_INC) begin
      r = p + 8'h01;
    end
    return r;
  endfunction

  logic [1:0] mode0;
  logic [1:0] mode1;
  assign mode0 = alu_status_register[cag_pkg::MODE0_LSB +: 2];
  assign mode1 = alu_status_register[cag_pkg::MODE1_LSB +: 2];

  // Pointers move on the cycle the memory access is presented, so the
  // address already issued is the pre-update value.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr0_reg <= cag_pkg::RST_BYTE;
    end else if (wr_lo && avs_address == cag_pkg::OFF_PTR0) begin
      ptr0_reg <= wbyte;
    end else if (ind_busy && !acc_sel_reg) begin
      ptr0_reg <= step_ptr(ptr0_reg, mode0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr1_reg <= cag_pkg::RST_BYTE;
    end else if (wr_lo && avs_address == cag_pkg::OFF_PTR1) begin
      ptr1_reg <= wbyte;
    end else if (ind_busy && acc_sel_reg) begin
      ptr1_reg <= step_ptr(ptr1_reg, mode1);
    end
  end

  // Pointer stepping has no path into this register at all.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_status_register <= cag_pkg::RST_ALU_STATUS;
    end else begin
      if (wr_lo && avs_address == cag_pkg::OFF_ALU_STATUS) begin
        alu_status_register <= wbyte;
      end else if (alu_flag_we) begin
        alu_status_register[3:0] <= alu_flags;
      end
      if (zero_set) begin
        alu_status_register[cag_pkg::ZERO_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_port_read_zero: assert property (
    ind_take && !ind_write && to_port |-> ##2 ind_done && ind_rdata == 8'h00
      ##1 alu_status_register[cag_pkg::ZERO_BIT])
    else $error("indirect read of a port did not give zero with Z");
  a_void_no_write: assert property (
    ind_take && ind_write && forced |=> !dmem_we)
    else $error("forced no-op write reached memory");
  a_ptr_increment: assert property (
    ind_busy && !acc_sel_reg && mode0 == 2'h1 && !wr_lo
      |=> ptr0_reg == $past(ptr0_reg) + 8'h01)
    else $error("pointer zero did not post-increment");
  a_ptr_hold: assert property (
    ind_busy && acc_sel_reg && mode1[1] && !wr_lo |=> $stable(ptr1_reg))
    else $error("pointer one moved in hold mode");
  a_step_no_flag: assert property (
    ind_busy && !zero_set && !alu_flag_we && !wr_lo
      |=> $stable(alu_status_register))
    else $error("pointer step changed status");
  a_done_in_cycle: assert property (
    ind_take |-> ##1 ind_busy ##1 ind_done)
    else $error("indirect transfer not done in two cycles");
  a_pc_increment: assert property (
    op_take && op == cag_pkg::PC_INCR && !pcl_bus_write
      |=> pc_out == $past(pc_out) + 16'h0001)
    else $error("counter did not increment on fetch");
  a_long_call: assert property (
    op_take && op == cag_pkg::PC_LONG_CALL && !pcl_bus_write && !wr_lo
      && !pcl_read |=> pc_out[15:8] == $past(pc_high_holding_latch)
      && $stable(pc_high_holding_latch))
    else $error("long call target or latch wrong");
  a_call_latch: assert property (
    op_take && op == cag_pkg::PC_CALL_JUMP && !wr_lo
      |=> pc_high_holding_latch[4:0] == $past(opcode[12:8]))
    else $error("call did not load latch bits");
  a_unimpl_bank: assert property (
    ind_take && !impl && !forced |=> !dmem_re && !dmem_we ##1 ind_done)
    else $error("unimplemented bank was accessed");
  a_bus_answer: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle later");

  c_ind_read: cover property (ind_take && !ind_write ##2 ind_done);
  c_ind_write: cover property (ind_take && ind_write && !forced);
  c_call_jump: cover property (op_take && op == cag_pkg::PC_CALL_JUMP);
  c_pcl_write: cover property (pcl_bus_write);
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the address generation block.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op; logic [15:0] opc; logic [7:0] wd; logic [15:0] base;
    logic [7:0] lat; logic [15:0] tgt; logic [15:0] exp_pc;
    logic [7:0] exp_lat; logic exp_nop;
  } cag_row_s;
  logic core_clk, rst_n, avs_read, avs_write, pcl_read, ind_req;
  logic ind_write, ind_sel, table_latch_load, load_peripheral_bank;
  logic load_ram_bank;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic [2:0] pc_op;
  logic [15:0] opcode, stack_top, vector_addr, table_latch_data, pc_out;
  logic [7:0] pc_wdata, ind_wdata, dmem_rdata, pc_high_holding_latch;
  logic [7:0] alu_status_register, bank_select_register, dmem_addr;
  logic [7:0] dmem_wdata, ind_rdata, c_addr, c_wd;
  logic [15:0] table_addr, table_holding_latch;
  logic [3:0] dmem_bank, c_bank;
  logic avs_waitrequest, first_clock_phase, forced_nop, dmem_re, dmem_we;
  logic ind_busy, ind_done, c_re, c_we;
  int n_errors, samples_checked, cyc;
  cag_row_s rows [8];

  cag_core #(.INSTR_CYCLES(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pc_op(pc_op), .opcode(opcode), .pc_wdata(pc_wdata),
    .stack_top(stack_top), .vector_addr(vector_addr),
    .pcl_read(pcl_read), .load_peripheral_bank(load_peripheral_bank),
    .load_ram_bank(load_ram_bank), .alu_flag_we(1'b0), .alu_flags(4'h0),
    .ind_req(ind_req), .ind_write(ind_write), .ind_sel(ind_sel),
    .ind_wdata(ind_wdata), .dmem_rdata(dmem_rdata),
    .table_latch_load(table_latch_load),
    .table_latch_data(table_latch_data),
    .first_clock_phase(first_clock_phase), .pc_out(pc_out),
    .forced_nop(forced_nop), .pc_high_holding_latch(pc_high_holding_latch),
    .alu_status_register(alu_status_register),
    .bank_select_register(bank_select_register), .table_addr(table_addr),
    .table_holding_latch(table_holding_latch), .dmem_addr(dmem_addr),
    .dmem_bank(dmem_bank), .dmem_re(dmem_re), .dmem_we(dmem_we),
    .dmem_wdata(dmem_wdata), .ind_busy(ind_busy), .ind_done(ind_done),
    .ind_rdata(ind_rdata)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Waitrequest and read data are taken at the completing rising edge.
  task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task ph;
    do @(negedge core_clk); while (first_clock_phase !== 1'b1);
    @(posedge core_clk);
  endtask
  task ind(input logic s, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    ind_req <= 1'b1;
    ind_sel <= s;
    ind_write <= w;
    ind_wdata <= d;
    @(posedge core_clk);
    ind_req <= 1'b0;
    @(negedge core_clk);
    {c_re, c_we, c_addr, c_bank, c_wd} =
      {dmem_re, dmem_we, dmem_addr, dmem_bank, dmem_wdata};
    @(negedge core_clk);
    chk(16'(ind_done), 16'h0001);
    // The zero flag lands one cycle after the read result.
    @(negedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, pcl_read, ind_req, ind_write} = '0;
    {ind_sel, table_latch_load, load_peripheral_bank, load_ram_bank} = '0;
    {avs_address, avs_writedata, opcode, pc_wdata, ind_wdata} = '0;
    {table_latch_data, vector_addr} = '0;
    // Idle op is a return to a fixed address, so the counter never drifts.
    pc_op = cag_pkg::PC_RETURN;
    stack_top = 16'h03F0;
    dmem_rdata = 8'h6C;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    rows[0] = '{cag_pkg::PC_INCR, 16'h0, 8'h0, 16'h03F0, 8'h11, 16'h0,
                16'h03F1, 8'h11, 1'b0};
    rows[1] = '{cag_pkg::PC_LONG_CALL, 16'h00A5, 8'h0, 16'h03F0, 8'h12,
                16'h0, 16'h12A5, 8'h12, 1'b0};
    rows[2] = '{cag_pkg::PC_CALL_JUMP, 16'h1ABC, 8'h0, 16'hE3F0, 8'h13,
                16'h0, 16'hFABC, 8'hFA, 1'b0};
    rows[3] = '{cag_pkg::PC_RETURN, 16'h0, 8'h0, 16'h03F0, 8'h14, 16'h4567,
                16'h4567, 8'h14, 1'b0};
    rows[4] = '{cag_pkg::PC_VECTOR, 16'h0, 8'h0, 16'h03F0, 8'h15, 16'h0020,
                16'h0020, 8'h15, 1'b0};
    rows[5] = '{cag_pkg::PC_WRITE_LOW, 16'h0, 8'h5A, 16'h03F0, 8'h16, 16'h0,
                16'h165A, 8'h16, 1'b0};
    rows[6] = '{cag_pkg::PC_RMW_LOW, 16'h0, 8'h20, 16'h03F0, 8'h03, 16'h0,
                16'h0320, 8'h03, 1'b0};
    rows[7] = '{cag_pkg::PC_SKIP, 16'h0, 8'h0, 16'h03F0, 8'h17, 16'h0,
                16'h03F1, 8'h17, 1'b1};
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(pc_out, 16'h0000);
    chk(16'(alu_status_register), 16'h00F0);
    chk(16'(bank_select_register), 16'h0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      stack_top <= rows[i].base;
      vector_addr <= rows[i].tgt;
      bus(1'b1, cag_pkg::OFF_PC_LATCH, rows[i].lat);
      ph();
      pc_op <= rows[i].op;
      opcode <= rows[i].opc;
      pc_wdata <= rows[i].wd;
      if (rows[i].op == cag_pkg::PC_RETURN) stack_top <= rows[i].tgt;
      ph();
      pc_op <= cag_pkg::PC_RETURN;
      stack_top <= 16'h03F0;
      @(negedge core_clk);
      chk(pc_out, rows[i].exp_pc);
      chk(16'(pc_high_holding_latch), 16'(rows[i].exp_lat));
      chk(16'(forced_nop), 16'(rows[i].exp_nop));
    end
    $display("test program counter rows done");
    bus(1'b1, cag_pkg::OFF_ALU_STATUS, 8'h10);
    bus(1'b1, cag_pkg::OFF_PTR0, 8'hFF);
    ind(1'b0, 1'b0, 8'h00);
    chk({c_re, 7'h0, c_addr}, 16'h80FF);
    chk(16'(ind_rdata), 16'h006C);
    bus(1'b0, cag_pkg::OFF_PTR0, 8'h00);
    chk(rd_val[15:0], 16'h0000);
    chk(16'(alu_status_register), 16'h0010);
    ind(1'b0, 1'b0, 8'h00);
    chk({7'h0, alu_status_register[cag_pkg::ZERO_BIT], ind_rdata},
        16'h0100);
    bus(1'b1, cag_pkg::OFF_BANK_SELECT, 8'h25);
    bus(1'b1, cag_pkg::OFF_ALU_STATUS, 8'h00);
    bus(1'b1, cag_pkg::OFF_PTR1, 8'h30);
    ind(1'b1, 1'b1, 8'h9D);
    chk({c_we, 3'h0, c_bank, c_addr}, 16'h8230);
    chk(16'(c_wd), 16'h009D);
    bus(1'b0, cag_pkg::OFF_PTR1, 8'h00);
    chk(rd_val[15:0], 16'h002F);
    bus(1'b1, cag_pkg::OFF_ALU_STATUS, 8'hA0);
    bus(1'b1, cag_pkg::OFF_PTR0, 8'h15);
    ind(1'b0, 1'b0, 8'h00);
    chk(16'(c_bank), 16'h0005);
    bus(1'b0, cag_pkg::OFF_PTR0, 8'h00);
    chk(rd_val[15:0], 16'h0015);
    bus(1'b1, cag_pkg::OFF_PTR0, cag_pkg::ADDR_IND_PORT1);
    ind(1'b0, 1'b0, 8'h00);
    chk({7'h0, alu_status_register[cag_pkg::ZERO_BIT], ind_rdata},
        16'h0100);
    bus(1'b1, cag_pkg::OFF_BANK_SELECT, 8'hF0);
    bus(1'b1, cag_pkg::OFF_PTR1, 8'h40);
    ind(1'b1, 1'b0, 8'h00);
    chk({7'h0, c_re, ind_rdata}, 16'h0000);
    bus(1'b1, cag_pkg::OFF_PTR1, 8'h00);
    ind(1'b1, 1'b1, 8'h77);
    chk(16'(c_we), 16'h0000);
    $display("test indirect access done");
    bus(1'b1, cag_pkg::OFF_TABLE_PTR_LOW, 8'h34);
    bus(1'b1, cag_pkg::OFF_TABLE_PTR_HIGH, 8'h12);
    @(posedge core_clk);
    {pcl_read, load_peripheral_bank, table_latch_load} <= 3'h7;
    load_ram_bank <= 1'b1;
    opcode <= 16'h0057;
    table_latch_data <= 16'hBEEF;
    @(posedge core_clk);
    {pcl_read, load_peripheral_bank, table_latch_load} <= 3'h0;
    load_ram_bank <= 1'b0;
    @(negedge core_clk);
    chk(table_addr, 16'h1234);
    chk(table_holding_latch, 16'hBEEF);
    chk(16'(pc_high_holding_latch), 16'h0003);
    chk(16'(bank_select_register), 16'h0057);
    bus(1'b0, cag_pkg::OFF_PC_FULL, 8'h00);
    chk(rd_val[15:0], 16'h03F0);
    $display("test registers done");
    close_out;
  end
endmodule
